// ==== core/lcr_pkg.sv ====
// constants and types for the result processing and range control block
// assumes one 20 MHz clock and an AXI4-Lite register port with byte addresses
package lcr_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MEAN = 8'h04;
  localparam logic [7:0] ADDR_NOM = 8'h08;
  localparam logic [7:0] ADDR_TRIG = 8'h0C;
  localparam logic [7:0] ADDR_RES_A = 8'h10;
  localparam logic [7:0] ADDR_RES_B = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_RANGE = 8'h1C;
  localparam int DISP_LSB = 0;
  localparam int LEVEL_LSB = 2;
  localparam int SPEED_LSB = 4;
  localparam int FIXED_BIT = 6;
  localparam int SINGLE_BIT = 7;
  localparam int HF_BIT = 8;
  // direct display, 1 V, slow, self-ranging, repeating
  localparam logic [8:0] CTRL_RST = 9'h020;
  localparam logic [6:0] MEAN_RST = 7'h01;
  localparam logic [6:0] MEAN_MAX = 7'h63;
  localparam logic [2:0] RANGE_RST = 3'h0;
  localparam logic [2:0] RANGE_LAST = 3'h4;
  localparam logic [2:0] RANGE_HF_MIN = 3'h1;
  // boundary i lies between range i and range i+1, in ohms
  localparam logic [31:0] UP_OHM [4] = '{32'h0000A410, 32'h00001068, 32'h000001A4, 32'h0000002A};
  localparam logic [31:0] DOWN_OHM [4] = '{32'h00009C40, 32'h00000FA0, 32'h00000190, 32'h00000028};
  localparam logic [6:0] DIGITS_TO5 = 7'h3B;
  localparam logic [6:0] DIGITS_TO4 = 7'h3E;
  // percent times 100 gives hundredths of a percent
  localparam logic [15:0] PCT_SCALE = 16'h2710;
  localparam int DIV_W = 48;
  localparam logic [5:0] DIV_STEPS = 6'h2F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DISP_DIR, DISP_ABS, DISP_PCT, DISP_VI} disp_t;
  typedef enum logic [1:0] {LEVEL_1V0, LEVEL_0V3, LEVEL_0V1} level_t;
  typedef enum logic [1:0] {SPEED_FAST, SPEED_MED, SPEED_SLOW} speed_t;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_WAIT, ST_MEAN, ST_DEV, ST_PCT, ST_OUT} state_t;
endpackage : lcr_pkg

// ==== core/div_if.sv ====
// request and answer signals between the result engine and its divider
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic start;
  logic signed [47:0] num;
  logic signed [31:0] den;
  logic done;
  logic signed [47:0] quo;
  modport client (output start, output num, output den, input done, input quo);
  modport unit (input start, input num, input den, output done, output quo);
endinterface : div_if
`default_nettype wire

// ==== core/lcr_divider.sv ====
// signed restoring divider, quotient truncated toward zero
// assumes start is a one-cycle pulse given while idle; a zero divisor is kept out by the caller
`timescale 1ns/1ps
`default_nettype none
module lcr_divider (
  input wire logic aclk,
  input wire logic aresetn,
  div_if.unit port
);
  import lcr_pkg::*;
  typedef struct packed {
    logic busy;
    logic done;
    logic neg;
    logic [5:0] cnt;
    logic [32:0] rem;
    logic [47:0] q;
    logic [31:0] d;
  } div_t;
  div_t q, d;

  always_comb
  begin
    logic [32:0] sh;
    logic [47:0] qq;
    sh = '0;
    qq = '0;
    d = q;
    d.done = 1'b0;
    if (!q.busy && port.start)
    begin
      d.busy = 1'b1;
      d.neg = port.num[47] ^ port.den[31];
      d.q = port.num[47] ? 48'(-port.num) : port.num;
      d.d = port.den[31] ? 32'(-port.den) : port.den;
      d.rem = '0;
      d.cnt = DIV_STEPS;
    end
    else if (q.busy)
    begin
      sh = {q.rem[31:0], q.q[47]};
      qq = {q.q[46:0], 1'b0};
      if (sh >= {1'b0, q.d})
      begin
        sh = sh - {1'b0, q.d};
        qq[0] = 1'b1;
      end
      d.rem = sh;
      d.q = qq;
      d.cnt = q.cnt - 6'h01;
      if (q.cnt == 6'h00)
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.q = q.neg ? 48'(-qq) : qq;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  assign port.done = q.done;
  assign port.quo = q.q;
endmodule : lcr_divider
`default_nettype wire

// ==== core/lcr_result_processing_autorange.sv ====
// result processing, averaging, display digits and range control of an impedance meter
// assumes the analog front end answers each meas_start with one meas_done pulse
//
// Behaviour
// RQ1 - absolute deviation shows mean minus nominal, signed, in plain value units
// RQ2 - software stores the nominal before choosing a deviation display
// RQ3 - percent deviation is (mean minus nominal)/nominal in hundredths of percent
// RQ4 - monitor display: display A carries volts, display B carries microamps
// RQ5 - four to five digits below 59, five to four above 62, else keep
// RQ6 - test level selectable 1V, 0.3V, 0.1V; 1V after reset
// RQ7 - speed selectable fast, medium, slow for the front end
// RQ8 - mean count 1 to 99, 1 after reset
// RQ9 - repeating mode outputs one mean after every N measurements
// RQ10 - one-shot trigger yields N outputs, k-th is mean of first k
// RQ11 - five impedance ranges 0 to 4, highest impedance first
// RQ12 - self-ranging checks each measurement and remeasures after a range change
// RQ13 - each boundary has an upward threshold above its downward threshold
// RQ14 - above 10 kHz range 0 is never used
// RQ15 - fixed range skips range evaluation entirely
// RQ16 - leaving self-ranging keeps the last chosen range
// RQ17 - zero nominal flags percent deviation invalid without dividing
// RQ18 - four displays: plain, absolute deviation, percent deviation, monitor
// RQ19 - one-shot measures only on trigger; repeating restarts at once
`timescale 1ns/1ps
`default_nettype none
module lcr_result_processing_autorange (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic meas_start,
  output logic [2:0] meas_range,
  output var lcr_pkg::level_t level_sel,
  output var lcr_pkg::speed_t speed_sel,
  input wire logic meas_done,
  input wire logic signed [31:0] meas_value,
  input wire logic [31:0] meas_ohm,
  input wire logic signed [31:0] meas_volt,
  input wire logic signed [31:0] meas_curr_ua,
  output logic result_valid,
  output logic signed [31:0] disp_a,
  output logic signed [31:0] disp_b,
  output logic five_digits,
  output logic pct_invalid
);
  import lcr_pkg::*;

  typedef struct packed {
    state_t st;
    logic [8:0] ctrl;
    logic [6:0] mean_n;
    logic signed [31:0] nom;
    logic [2:0] range;
    logic trig;
    logic [6:0] n_run;
    logic [6:0] cnt;
    logic signed [39:0] sum;
    logic signed [31:0] mean;
    logic signed [31:0] volt;
    logic signed [31:0] curr;
    logic signed [31:0] a;
    logic signed [31:0] b;
    logic five;
    logic inval;
    logic res_v;
    logic div_go;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } regs_t;

  localparam regs_t RST = '{st: ST_IDLE, ctrl: CTRL_RST, mean_n: MEAN_RST, range: RANGE_RST,
                            five: 1'b1, default: '0};

  regs_t q, d;
  div_if dv ();

  lcr_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(dv.unit)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // leading-two-digit bands per decade of the displayed magnitude
  logic [31:0] mag;
  logic [8:0] lo;
  logic [8:0] hi;
  assign mag = q.a[31] ? 32'(-q.a) : q.a;
  for (genvar k = 0; k < 9; k++)
  begin : g_dec
    localparam longint P = longint'(10) ** k;
    logic inr;
    assign inr = (64'(mag) >= 10 * P) && (64'(mag) < 100 * P);
    assign lo[k] = inr && (64'(mag) < 64'(DIGITS_TO5) * P); // see RQ5
    assign hi[k] = inr && (64'(mag) >= (64'(DIGITS_TO4) + 1) * P); // see RQ5
  end

  // range check against the hysteresis pair on either side of the current range
  logic [2:0] rmin;
  logic go_up;
  logic go_dn;
  assign rmin = q.ctrl[HF_BIT] ? RANGE_HF_MIN : RANGE_RST; // see RQ14
  assign go_up = (q.range > rmin) && (meas_ohm > UP_OHM[2'(q.range - 3'h1)]); // see RQ13
  assign go_dn = (q.range < RANGE_LAST) && (meas_ohm < DOWN_OHM[q.range[1:0]]); // see RQ13

  logic signed [32:0] diff;
  logic signed [47:0] pct_num;
  assign diff = 33'(q.mean) - 33'(q.nom); // see RQ1
  assign pct_num = 48'(diff) * 48'(PCT_SCALE); // see RQ3

  assign dv.start = q.div_go;
  assign dv.num = (q.st == ST_PCT) ? pct_num : 48'(q.sum);
  assign dv.den = (q.st == ST_PCT) ? q.nom : 32'(q.cnt);

  always_comb
  begin
    logic [31:0] w;
    logic [31:0] rd;
    logic ok;
    w = '0;
    rd = '0;
    ok = 1'b0;
    d = q;
    d.res_v = 1'b0;
    d.div_go = 1'b0;
    case (q.st)
      ST_IDLE:
      begin
        if (!q.ctrl[SINGLE_BIT] || q.trig) // see RQ19
        begin
          d.trig = 1'b0;
          d.n_run = q.mean_n;
          d.cnt = '0;
          d.sum = '0;
          d.st = ST_START;
        end
      end
      ST_START:
        d.st = ST_WAIT;
      ST_WAIT:
      begin
        if (meas_done)
        begin
          // a measurement taken in the wrong range is thrown away, not averaged
          if (!q.ctrl[FIXED_BIT] && (go_up || go_dn)) // see RQ12, see RQ15
          begin
            d.range = go_up ? q.range - 3'h1 : q.range + 3'h1; // see RQ11
            d.st = ST_START;
          end
          else
          begin
            d.sum = q.sum + 40'(meas_value);
            d.cnt = q.cnt + 7'h01;
            d.volt = meas_volt;
            d.curr = meas_curr_ua;
            if (q.ctrl[SINGLE_BIT] || (d.cnt >= q.n_run)) // see RQ9, see RQ10
            begin
              d.div_go = 1'b1;
              d.st = ST_MEAN;
            end
            else
              d.st = ST_START; // see RQ19
          end
        end
      end
      ST_MEAN:
      begin
        if (dv.done)
        begin
          d.mean = dv.quo[31:0];
          d.st = ST_DEV;
        end
      end
      ST_DEV:
      begin
        d.inval = 1'b0;
        d.b = '0;
        d.st = ST_OUT;
        case (disp_t'(q.ctrl[DISP_LSB +: 2])) // see RQ18
          DISP_ABS:
            d.a = diff[31:0]; // see RQ1
          DISP_PCT:
          begin
            if (q.nom == '0) // see RQ17
            begin
              d.inval = 1'b1;
              d.a = '0;
            end
            else
            begin
              d.div_go = 1'b1;
              d.st = ST_PCT; // see RQ3
            end
          end
          DISP_VI:
          begin
            d.a = q.volt; // see RQ4
            d.b = q.curr;
          end
          default:
            d.a = q.mean;
        endcase
      end
      ST_PCT:
      begin
        if (dv.done)
        begin
          d.a = dv.quo[31:0];
          d.st = ST_OUT;
        end
      end
      ST_OUT:
      begin
        d.res_v = 1'b1;
        if (q.five && (|hi)) // see RQ5
          d.five = 1'b0;
        else if (!q.five && (|lo))
          d.five = 1'b1;
        if (!q.ctrl[SINGLE_BIT])
        begin
          d.cnt = '0;
          d.sum = '0;
          d.n_run = q.mean_n;
          d.st = ST_START; // see RQ19
        end
        else if (q.cnt >= q.n_run) // see RQ10
          d.st = ST_IDLE;
        else
          d.st = ST_START;
      end
      default:
        d.st = ST_IDLE;
    endcase

    // register writes land after the sequencer so a trigger write wins over its clear
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      ok = 1'b1;
      d.bvalid = 1'b1;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      case ({q.aw_addr[7:2], 2'b00})
        ADDR_CTRL:
        begin
          w = merge(32'(q.ctrl), q.wdata, q.wstrb);
          if (w[LEVEL_LSB +: 2] == 2'h3) // see RQ6
            w[LEVEL_LSB +: 2] = q.ctrl[LEVEL_LSB +: 2];
          if (w[SPEED_LSB +: 2] == 2'h3) // see RQ7
            w[SPEED_LSB +: 2] = q.ctrl[SPEED_LSB +: 2];
          d.ctrl = w[8:0]; // see RQ16
        end
        ADDR_MEAN:
        begin
          w = merge(32'(q.mean_n), q.wdata, q.wstrb);
          if (w == '0) // see RQ8
            d.mean_n = MEAN_RST;
          else if (w > 32'(MEAN_MAX))
            d.mean_n = MEAN_MAX;
          else
            d.mean_n = w[6:0];
        end
        ADDR_NOM:
          d.nom = merge(q.nom, q.wdata, q.wstrb); // see RQ2
        ADDR_TRIG:
        begin
          if (q.wstrb[0] && q.wdata[0])
            d.trig = 1'b1;
        end
        ADDR_RANGE:
        begin
          if (q.wstrb[0])
            d.range = (q.wdata[2:0] > RANGE_LAST) ? RANGE_LAST : q.wdata[2:0];
        end
        ADDR_RES_A, ADDR_RES_B, ADDR_STATUS:
          ok = 1'b1;
        default:
          ok = 1'b0;
      endcase
      d.bresp = ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.bvalid && bready)
      d.bvalid = 1'b0;
    if (!q.aw_got && !q.bvalid && awvalid)
    begin
      d.aw_got = 1'b1;
      d.aw_addr = awaddr;
    end
    if (!q.w_got && !q.bvalid && wvalid)
    begin
      d.w_got = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end

    if (q.rvalid && rready)
      d.rvalid = 1'b0;
    if (!q.rvalid && arvalid)
    begin
      ok = 1'b1;
      case ({araddr[7:2], 2'b00})
        ADDR_CTRL:
          rd = 32'(q.ctrl);
        ADDR_MEAN:
          rd = 32'(q.mean_n);
        ADDR_NOM:
          rd = q.nom;
        ADDR_TRIG:
          rd = '0;
        ADDR_RES_A:
          rd = q.a;
        ADDR_RES_B:
          rd = q.b;
        ADDR_STATUS:
          rd = {26'h0000000, q.st != ST_IDLE, q.inval, q.five, q.range};
        ADDR_RANGE:
          rd = 32'(q.range);
        default:
          ok = 1'b0;
      endcase
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = ok ? RESP_OKAY : RESP_SLVERR;
    end

    if (d.ctrl[HF_BIT] && (d.range == RANGE_RST)) // see RQ14
      d.range = RANGE_HF_MIN;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= RST;
    else
      q <= d;
  end

  assign awready = !q.aw_got && !q.bvalid;
  assign wready = !q.w_got && !q.bvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = !q.rvalid;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign meas_start = (q.st == ST_START);
  assign meas_range = q.range;
  assign level_sel = level_t'(q.ctrl[LEVEL_LSB +: 2]);
  assign speed_sel = speed_t'(q.ctrl[SPEED_LSB +: 2]);
  assign result_valid = q.res_v;
  assign disp_a = q.a;
  assign disp_b = q.b;
  assign five_digits = q.five;
  assign pct_invalid = q.inval;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  abs_dev_a: assert property ( // see RQ1
    q.st == ST_DEV && q.ctrl[1:0] == 2'h1 |=> disp_a == 32'($past(q.mean) - $past(q.nom)))
    else $error("absolute deviation wrong");
  pct_zero_a: assert property ( // see RQ17
    q.st == ST_DEV && q.ctrl[1:0] == 2'h2 && q.nom == '0 |=> pct_invalid ##1 result_valid)
    else $error("zero nominal not flagged");
  vi_disp_a: assert property ( // see RQ4
    q.st == ST_DEV && q.ctrl[1:0] == 2'h3 |=> disp_a == q.volt && disp_b == q.curr)
    else $error("monitor display wrong");
  digit_up_a: assert property ( // see RQ5
    q.st == ST_OUT && !q.five && (|lo) |=> five_digits && result_valid)
    else $error("five digits not taken");
  hf_range_a: assert property ( // see RQ14
    q.ctrl[HF_BIT] |-> meas_range != 3'h0)
    else $error("range 0 used at high frequency");
  fixed_hold_a: assert property ( // see RQ15
    q.st == ST_WAIT && meas_done && q.ctrl[FIXED_BIT] && !q.aw_got |=> $stable(meas_range))
    else $error("range moved in fixed mode");
  auto_step_a: assert property ( // see RQ12
    q.st == ST_WAIT && meas_done && !q.ctrl[FIXED_BIT] && go_up && !q.aw_got
    |=> meas_range == $past(q.range) - 3'h1 && meas_start)
    else $error("range step or remeasure missing");
  repeat_n_a: assert property ( // see RQ9
    q.st == ST_OUT && !q.ctrl[SINGLE_BIT] |-> q.cnt == q.n_run)
    else $error("repeating mean over wrong count");
  single_mean_a: assert property ( // see RQ10
    q.st == ST_WAIT && meas_done && q.ctrl[SINGLE_BIT] && !(go_up || go_dn)
    |=> q.st == ST_MEAN ##[40:60] q.st == ST_DEV)
    else $error("one-shot step not averaged");
  reset_dflt_a: assert property ( // see RQ6
    $rose(aresetn) |-> level_sel == LEVEL_1V0 && q.mean_n == MEAN_RST)
    else $error("power-on defaults wrong");
  single_idle_a: assert property ( // see RQ19
    q.st == ST_IDLE && q.ctrl[SINGLE_BIT] && !q.trig |=> !meas_start)
    else $error("measurement without trigger");
endmodule : lcr_result_processing_autorange
`default_nettype wire

// ==== tb/lcr_front_end_model.sv ====
// stand-in for the analog front end: one answer per measurement request
// assumes the bench supplies the values to report and the latency in cycles
`timescale 1ns/1ps
`default_nettype none
module lcr_front_end_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic meas_start,
  input wire logic [7:0] lat,
  input wire logic signed [31:0] val_in,
  input wire logic [31:0] ohm_in,
  input wire logic signed [31:0] volt_in,
  input wire logic signed [31:0] curr_in,
  output logic meas_done,
  output logic signed [31:0] meas_value,
  output logic [31:0] meas_ohm,
  output logic signed [31:0] meas_volt,
  output logic signed [31:0] meas_curr_ua
);
  logic busy_q = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  // outside the done cycle the data toggle, so a stale value is never taken as fresh
  always @(posedge aclk)
  begin
    meas_done <= 1'b0;
    meas_value <= ~meas_value;
    meas_ohm <= ~meas_ohm;
    meas_volt <= ~meas_volt;
    meas_curr_ua <= ~meas_curr_ua;
    if (!aresetn)
    begin
      busy_q <= 1'b0;
      meas_value <= 32'sh0;
      meas_ohm <= 32'h0;
      meas_volt <= 32'sh0;
      meas_curr_ua <= 32'sh0;
    end
    else if (busy_q && cnt_q <= 8'h01)
    begin
      busy_q <= 1'b0;
      meas_done <= 1'b1;
      meas_value <= val_in;
      meas_ohm <= ohm_in;
      meas_volt <= volt_in;
      meas_curr_ua <= curr_in;
    end
    else if (busy_q)
      cnt_q <= cnt_q - 8'h01;
    else if (meas_start)
    begin
      busy_q <= 1'b1;
      cnt_q <= lat;
    end
  end
endmodule : lcr_front_end_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the result processing and range control block
// assumes the front end model drives the measurement link
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lcr_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, lat = 8'h01;
  logic [31:0] wdata = 32'h0, rdata, ohm_in = 32'h0, seed = 32'h144B, vseed = 32'h144B, rd;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, meas_start, meas_done, result_valid;
  logic five_digits, pct_invalid, five_exp = 1'b1;
  logic [2:0] meas_range;
  level_t level_sel;
  speed_t speed_sel;
  logic signed [31:0] meas_value, meas_volt, meas_curr_ua, disp_a, disp_b;
  logic signed [31:0] val_in = 32'sh0, volt_in = 32'sh0, curr_in = 32'sh0;
  logic [31:0] meas_ohm;
  int bad_count = 0, num_checks = 0, starts = 0;
  longint seen[$];
  longint nom, m;
  always #25 aclk = ~aclk;
  lcr_result_processing_autorange u_lcr_result_processing_autorange (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .meas_start(meas_start),
    .meas_range(meas_range), .level_sel(level_sel), .speed_sel(speed_sel),
    .meas_done(meas_done), .meas_value(meas_value), .meas_ohm(meas_ohm),
    .meas_volt(meas_volt), .meas_curr_ua(meas_curr_ua), .result_valid(result_valid),
    .disp_a(disp_a), .disp_b(disp_b), .five_digits(five_digits), .pct_invalid(pct_invalid));
  lcr_front_end_model u_lcr_front_end_model (.aclk(aclk), .aresetn(aresetn),
    .meas_start(meas_start), .lat(lat), .val_in(val_in), .ohm_in(ohm_in), .volt_in(volt_in),
    .curr_in(curr_in), .meas_done(meas_done), .meas_value(meas_value), .meas_ohm(meas_ohm),
    .meas_volt(meas_volt), .meas_curr_ua(meas_curr_ua));
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr_next
  function automatic longint mean_of(input int k);
    longint s = 0;
    for (int i = 0; i < k; i++)
      s += seen[i];
    return s / k;
  endfunction : mean_of
  function automatic longint exp_a(input int d, input longint mv, input longint n);
    case (d)
      0: return mv;
      1: return mv - n;
      2: return (mv - n) * 10000 / n;
      default: return volt_in;
    endcase
  endfunction : exp_a
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad = 0, wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && awready)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready)
      begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd_reg
  task automatic wait_res();
    int n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (result_valid !== 1'b1 && n < 3000);
    if (n >= 3000)
      check("result_valid", 0, 1);
  endtask : wait_res
  // one-shot mode with no trigger pending stops the measurement loop cleanly
  task automatic halt(input logic [31:0] c);
    int n = 0;
    wr(ADDR_CTRL, c | 32'h80);
    do
    begin
      rd_reg(ADDR_STATUS);
      n++;
    end
    while (rd[5] !== 1'b0 && n < 500);
    check("busy", 32'(rd[5]), 0);
    seen.delete();
    starts = 0;
    $display("test step done, checks so far %0d", num_checks);
  endtask : halt
  task automatic range_run(input logic [31:0] c, input logic [31:0] ohm, input int n,
                           input logic [2:0] rng);
    ohm_in <= ohm;
    wr(ADDR_CTRL, c);
    wait_res();
    check("measurements", seen.size(), n);
    check("range", meas_range, rng);
    halt(c);
  endtask : range_run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  always @(posedge aclk)
  begin : watch
    longint a;
    if (meas_start === 1'b1)
      starts++;
    if (meas_done === 1'b1)
    begin
      seen.push_back(meas_value);
      vseed = lfsr_next(vseed);
      val_in <= {{11{vseed[20]}}, vseed[20:0]};
    end
    if (result_valid === 1'b1)
    begin
      a = disp_a < 0 ? -disp_a : disp_a;
      if (a >= 10)
      begin
        while (a >= 100)
          a = a / 10;
        if (five_exp && a > 62)
          five_exp = 1'b0;
        else if (!five_exp && a < 59)
          five_exp = 1'b1;
      end
      check("five_digits", five_digits, five_exp);
    end
  end
  initial
  begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("level_sel", level_sel, LEVEL_1V0);
    rd_reg(ADDR_MEAN);
    check("mean_count", rd, 1);
    rd_reg(8'h20);
    check("rresp", resp, RESP_SLVERR);
    check("rdata", rd, 0);
    wr(8'h24, 32'h0);
    check("bresp", resp, RESP_SLVERR);
    wr(ADDR_MEAN, 0);
    rd_reg(ADDR_MEAN);
    check("mean_count", rd, 1);
    wr(ADDR_MEAN, 100);
    rd_reg(ADDR_MEAN);
    check("mean_count", rd, 99);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_CTRL, 32'h80 | (i << 2) | ((2 - i) << 4));
      check("level_sel", level_sel, i);
      check("speed_sel", speed_sel, 2 - i);
    end
    // level and speed code 3 are refused, both fields keep their old setting
    wr(ADDR_CTRL, 32'hBC);
    check("level_sel", level_sel, LEVEL_0V1);
    check("speed_sel", speed_sel, SPEED_FAST);
    halt(32'h40);
    for (int d = 0; d < 4; d++)
    begin
      seed = lfsr_next(seed);
      nom = $signed({{12{seed[19]}}, seed[19:1], 1'b1});
      lat <= {3'h0, seed[25:21]} + 8'h01;
      volt_in <= {16'h0, seed[15:0]};
      curr_in <= -{17'h0, seed[30:16]};
      wr(ADDR_NOM, nom[31:0]);
      wr(ADDR_MEAN, 2);
      wr(ADDR_CTRL, 32'h40 | d);
      wait_res();
      m = mean_of(2);
      check("disp_a", disp_a, 32'(exp_a(d, m, nom)));
      check("disp_b", disp_b, d == 3 ? curr_in : 0);
      check("pct_invalid", pct_invalid, 0);
      halt(32'h40);
    end
    wr(ADDR_NOM, 0);
    wr(ADDR_CTRL, 32'h42);
    wait_res();
    check("pct_invalid", pct_invalid, 1);
    check("disp_a", disp_a, 0);
    halt(32'h40);
    wr(ADDR_MEAN, 3);
    repeat (200) @(posedge aclk);
    check("starts", starts, 0);
    wr(ADDR_TRIG, 1);
    for (int k = 1; k <= 3; k++)
    begin
      wait_res();
      check("one_shot", disp_a, 32'(mean_of(k)));
    end
    repeat (200) @(posedge aclk);
    check("starts", starts, 3);
    halt(32'h40);
    wr(ADDR_MEAN, 1);
    wr(ADDR_RANGE, 32'h7);
    rd_reg(ADDR_RANGE);
    check("range_reg", rd, 4);
    wr(ADDR_RANGE, 0);
    lat <= 8'h03;
    range_run(32'h000, 30, 5, 4);
    range_run(32'h000, 41, 1, 4);
    range_run(32'h000, 43, 2, 3);
    range_run(32'h100, 100000, 3, 1);
    range_run(32'h140, 30, 1, 1);
    wr(ADDR_RANGE, 0);
    rd_reg(ADDR_RANGE);
    check("range_reg", rd, 1);
    close_out();
  end
endmodule : tb
`default_nettype wire
